//--- core/tpm_pkg.sv
// Shared constants for the thermal protection monitor
`default_nettype none
package tpm_pkg;

  localparam int ADDR_W          = 12;
  localparam int IDX_W           = 10;
  localparam int REG_W           = 16;
  localparam int SYNC_STAGES     = 2;

  // Register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_ADD_CTRL1 = 10'h017;
  localparam logic [IDX_W-1:0] IDX_FLAGS     = 10'h02f;
  localparam logic [IDX_W-1:0] IDX_MON_EN    = 10'h030;
  localparam logic [IDX_W-1:0] IDX_OUT_EN    = 10'h031;
  localparam logic [IDX_W-1:0] IDX_PIN_CFG   = 10'h032;

  // Field positions
  localparam int AUTO_SHDN_BIT   = 8;
  localparam int HP_MON_BIT      = 2;
  localparam int SPK_MON_BIT     = 1;
  localparam int HP_ERR_BIT      = 3;
  localparam int HP_WARN_BIT     = 2;
  localparam int SPK_ERR_BIT     = 1;
  localparam int SPK_WARN_BIT    = 0;
  localparam int CP_EN_BIT       = 0;
  localparam int SPKL_EN_BIT     = 1;
  localparam int SPKR_EN_BIT     = 2;
  localparam int PIN_FUNC_BIT    = 0;
  localparam int PIN_ERR_SEL_BIT = 1;

  // Reset values
  localparam logic       AUTO_SHDN_RST = 1'b1;
  localparam logic [1:0] MON_EN_RST    = 2'h3;
  localparam logic [2:0] OUT_EN_RST    = 3'h0;
  localparam logic [1:0] PIN_CFG_RST   = 2'h0;
  localparam logic [3:0] FLAGS_RST     = 4'h0;

  // Sensor thresholds in degrees Celsius
  localparam int WARN_TEMP_C = 125;
  localparam int ERR_TEMP_C  = 145;

  typedef enum logic [0:0] {ST_NORMAL, ST_SHUTDOWN} tpm_state_t;

endpackage
`default_nettype wire

//--- core/tpm_sync.sv
// Multi-bit level synchroniser for comparator outputs
`timescale 1ns/100ps
`default_nettype none
module tpm_sync #(
  parameter int WIDTH  = 4,
  parameter int STAGES = tpm_pkg::SYNC_STAGES
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  if (STAGES < 2)
  begin : gBadStages
    $error("tpm_sync needs at least two stages");
  end

  genvar b;
  generate
    for (b = 0; b < WIDTH; b++)
    begin : gBit
      logic [STAGES-1:0] chain_r;
      // Chain of flops per bit
      always_ff @(posedge clk)
      begin
        if (reset)
          chain_r <= '0;
        else
          chain_r <= {chain_r[STAGES-2:0], asyncIn[b]};
      end
      assign syncOut[b] = chain_r[STAGES-1];
    end
  endgenerate

endmodule
`default_nettype wire

//--- core/tpm_monitor.sv
// Thermal protection monitor with APB registers and automatic shutdown
//
// Behaviour
// - Separate headphone and speaker warning/hazard classification
// - Each monitor runs only while enabled
// - Warning flag set at warning threshold
// - Error flag set at hazardous threshold
// - Any error cuts speakers and charge pump
// - Restore prior enables once temperature falls
// - Auto shutdown bit, needs a monitor enabled
// - Read-only flags register, reset zero
// - Temperature status drives configurable pin
// - Flag rises raise event pulses
`timescale 1ns/100ps
`default_nettype none
module tpm_monitor #(
  parameter int SYNC_STAGES = tpm_pkg::SYNC_STAGES
) (
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [tpm_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        hpWarnComp,
  input  wire logic                        hpErrComp,
  input  wire logic                        spkWarnComp,
  input  wire logic                        spkErrComp,
  output logic                             leftSpeakerOutputEnable,
  output logic                             rightSpeakerOutputEnable,
  output logic                             chargePumpEnable,
  output logic                             tempStatusPin,
  output logic                             tempStatusPinOe,
  output logic      [3:0]                  flagEvent,
  output logic                             shutdownActive
);

  if (SYNC_STAGES < 2)
  begin : gBadSync
    $error("tpm_monitor needs at least two synchroniser stages");
  end

  logic                       autoShutdown_r;
  logic [1:0]                 monEn_r;
  logic [2:0]                 outEn_r;
  logic [1:0]                 pinCfg_r;
  logic [3:0]                 flags_r;
  logic [3:0]                 flagsNxt;
  logic [3:0]                 compSync;
  logic [3:0]                 flagEvent_r;
  logic [31:0]                prdata_r;
  logic [31:0]                rdNxt;
  logic                       pslverr_r;
  logic                       mapped;
  logic                       setupPh;
  logic                       wrAcc;
  logic [tpm_pkg::IDX_W-1:0]  idx;
  logic                       leftSpk_r;
  logic                       rightSpk_r;
  logic                       cp_r;
  logic                       pin_r;
  logic                       pinOe_r;
  logic                       anyErr;
  logic                       anyFlag;
  logic                       hpOn;
  logic                       spkOn;
  tpm_pkg::tpm_state_t        state_r;

  tpm_sync #(
    .WIDTH  (4),
    .STAGES (SYNC_STAGES)
  ) uSync (
    .clk     (clk),
    .reset   (reset),
    .asyncIn ({hpErrComp, hpWarnComp, spkErrComp, spkWarnComp}),
    .syncOut (compSync)
  );

  assign idx     = paddr[tpm_pkg::ADDR_W-1:2];
  assign setupPh = psel && !penable;
  assign wrAcc   = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign mapped  = (idx == tpm_pkg::IDX_ADD_CTRL1) || (idx == tpm_pkg::IDX_FLAGS) ||
                   (idx == tpm_pkg::IDX_MON_EN) || (idx == tpm_pkg::IDX_OUT_EN) ||
                   (idx == tpm_pkg::IDX_PIN_CFG);
  assign hpOn    = monEn_r[tpm_pkg::HP_MON_BIT-1];
  assign spkOn   = monEn_r[tpm_pkg::SPK_MON_BIT-1];

  always_ff @(posedge clk)
  begin
    if (reset)
      autoShutdown_r <= tpm_pkg::AUTO_SHDN_RST;
    else if (wrAcc && idx == tpm_pkg::IDX_ADD_CTRL1 && pstrb[1])
      autoShutdown_r <= pwdata[tpm_pkg::AUTO_SHDN_BIT];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      monEn_r <= tpm_pkg::MON_EN_RST;
    else if (wrAcc && idx == tpm_pkg::IDX_MON_EN && pstrb[0])
      monEn_r <= pwdata[tpm_pkg::HP_MON_BIT:tpm_pkg::SPK_MON_BIT];
  end

  // Output and pin configuration
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      outEn_r  <= tpm_pkg::OUT_EN_RST;
      pinCfg_r <= tpm_pkg::PIN_CFG_RST;
    end
    else if (wrAcc && pstrb[0])
    begin
      if (idx == tpm_pkg::IDX_OUT_EN)
        outEn_r <= pwdata[tpm_pkg::SPKR_EN_BIT:tpm_pkg::CP_EN_BIT];
      if (idx == tpm_pkg::IDX_PIN_CFG)
        pinCfg_r <= pwdata[tpm_pkg::PIN_ERR_SEL_BIT:tpm_pkg::PIN_FUNC_BIT];
    end
  end

  always_comb
  begin
    flagsNxt = '0;
    flagsNxt[tpm_pkg::HP_WARN_BIT]  = compSync[tpm_pkg::HP_WARN_BIT] && hpOn;
    flagsNxt[tpm_pkg::SPK_WARN_BIT] = compSync[tpm_pkg::SPK_WARN_BIT] && spkOn;
    flagsNxt[tpm_pkg::HP_ERR_BIT]   = compSync[tpm_pkg::HP_ERR_BIT] && hpOn;
    flagsNxt[tpm_pkg::SPK_ERR_BIT]  = compSync[tpm_pkg::SPK_ERR_BIT] && spkOn;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      flags_r <= tpm_pkg::FLAGS_RST;
    else
      flags_r <= flagsNxt;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      flagEvent_r <= '0;
    else
      flagEvent_r <= flagsNxt & ~flags_r;
  end

  assign anyErr  = flags_r[tpm_pkg::HP_ERR_BIT] || flags_r[tpm_pkg::SPK_ERR_BIT];
  assign anyFlag = |flags_r;

  always_ff @(posedge clk)
  begin
    if (reset)
      state_r <= tpm_pkg::ST_NORMAL;
    else
    begin
      case (state_r)
        tpm_pkg::ST_NORMAL:
          if (autoShutdown_r && anyErr)
            state_r <= tpm_pkg::ST_SHUTDOWN;
        tpm_pkg::ST_SHUTDOWN:
          if (!anyErr || !autoShutdown_r)
            state_r <= tpm_pkg::ST_NORMAL;
        default:
          state_r <= tpm_pkg::ST_NORMAL;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      leftSpk_r  <= 1'b0;
      rightSpk_r <= 1'b0;
      cp_r       <= 1'b0;
    end
    else if (state_r == tpm_pkg::ST_SHUTDOWN)
    begin
      leftSpk_r  <= 1'b0;
      rightSpk_r <= 1'b0;
      cp_r       <= 1'b0;
    end
    else
    begin
      leftSpk_r  <= outEn_r[tpm_pkg::SPKL_EN_BIT];
      rightSpk_r <= outEn_r[tpm_pkg::SPKR_EN_BIT];
      cp_r       <= outEn_r[tpm_pkg::CP_EN_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin_r   <= 1'b0;
      pinOe_r <= 1'b0;
    end
    else
    begin
      pinOe_r <= pinCfg_r[tpm_pkg::PIN_FUNC_BIT];
      pin_r   <= pinCfg_r[tpm_pkg::PIN_FUNC_BIT] &&
                 (pinCfg_r[tpm_pkg::PIN_ERR_SEL_BIT] ? anyErr : anyFlag);
    end
  end

  always_comb
  begin
    rdNxt = '0;
    case (idx)
      tpm_pkg::IDX_ADD_CTRL1: rdNxt[tpm_pkg::AUTO_SHDN_BIT] = autoShutdown_r;
      tpm_pkg::IDX_FLAGS:     rdNxt[3:0] = flags_r;
      tpm_pkg::IDX_MON_EN:    rdNxt[tpm_pkg::HP_MON_BIT:tpm_pkg::SPK_MON_BIT] = monEn_r;
      tpm_pkg::IDX_OUT_EN:    rdNxt[2:0] = outEn_r;
      tpm_pkg::IDX_PIN_CFG:   rdNxt[1:0] = pinCfg_r;
      default:                rdNxt = '0;
    endcase
  end

  // Read data and error captured in setup
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end
    else if (setupPh)
    begin
      prdata_r  <= pwrite ? 32'h0000_0000 : rdNxt;
      pslverr_r <= !mapped;
    end
  end

  assign prdata                   = prdata_r;
  assign pslverr                  = pslverr_r;
  assign leftSpeakerOutputEnable  = leftSpk_r;
  assign rightSpeakerOutputEnable = rightSpk_r;
  assign chargePumpEnable         = cp_r;
  assign tempStatusPin            = pin_r;
  assign tempStatusPinOe          = pinOe_r;
  assign flagEvent                = flagEvent_r;
  assign shutdownActive           = (state_r == tpm_pkg::ST_SHUTDOWN);

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_SEPARATE_CLASS: assert property (
    compSync[tpm_pkg::HP_WARN_BIT] && !compSync[tpm_pkg::SPK_WARN_BIT] && hpOn
    |=> flags_r[tpm_pkg::HP_WARN_BIT] && !flags_r[tpm_pkg::SPK_WARN_BIT])
    else $error("headphone warning leaked into speaker flag");

  AST_MON_DISABLED: assert property (
    !hpOn |=> flags_r[tpm_pkg::HP_ERR_BIT:tpm_pkg::HP_WARN_BIT] == 2'h0)
    else $error("disabled headphone monitor shows flags");

  AST_WARN_SET: assert property (
    compSync[tpm_pkg::SPK_WARN_BIT] && spkOn |=> flags_r[tpm_pkg::SPK_WARN_BIT])
    else $error("speaker warning flag not set");

  AST_ERR_SET: assert property (
    compSync[tpm_pkg::HP_ERR_BIT] && hpOn |=> flags_r[tpm_pkg::HP_ERR_BIT])
    else $error("headphone error flag not set");

  AST_SHUTDOWN_OFF: assert property (
    shutdownActive |=> !leftSpeakerOutputEnable && !rightSpeakerOutputEnable
                       && !chargePumpEnable)
    else $error("outputs enabled during shutdown");

  AST_RESTORE: assert property (
    !shutdownActive |=> leftSpeakerOutputEnable == $past(outEn_r[tpm_pkg::SPKL_EN_BIT])
                        && chargePumpEnable == $past(outEn_r[tpm_pkg::CP_EN_BIT]))
    else $error("enables not restored after shutdown");

  AST_SHUTDOWN_ENTRY: assert property (
    !shutdownActive && autoShutdown_r && anyErr |=> shutdownActive)
    else $error("shutdown not entered on error");

  AST_NO_AUTO: assert property (
    !shutdownActive && !autoShutdown_r |=> !shutdownActive)
    else $error("shutdown entered while disabled");

  AST_FLAG_READ: assert property (
    setupPh && !pwrite && idx == tpm_pkg::IDX_FLAGS
    |=> prdata == {28'h0000000, $past(flags_r)})
    else $error("flags register read mismatch");

  AST_PIN: assert property (
    pinCfg_r == 2'h1 && $stable(pinCfg_r) && anyFlag |=> tempStatusPin && tempStatusPinOe)
    else $error("status pin not driven");

  AST_EVENT: assert property (
    $rose(flags_r[tpm_pkg::HP_ERR_BIT]) |-> flagEvent[tpm_pkg::HP_ERR_BIT]
    ##1 !flagEvent[tpm_pkg::HP_ERR_BIT])
    else $error("error event not a single pulse");

  AST_SYNC_DELAY: assert property (
    !flags_r[tpm_pkg::SPK_ERR_BIT] && !compSync[tpm_pkg::SPK_ERR_BIT]
    |=> !flags_r[tpm_pkg::SPK_ERR_BIT])
    else $error("flag set without synchronised input");

  COV_SHUTDOWN: cover property (!shutdownActive ##1 shutdownActive);
  COV_RESTORE: cover property (shutdownActive ##1 !shutdownActive ##1 leftSpeakerOutputEnable);
  COV_UNMAPPED: cover property (psel && penable && pslverr);
  COV_EVENT: cover property (flagEvent[tpm_pkg::SPK_WARN_BIT]);

endmodule
`default_nettype wire

//--- verif/tpm_sensor_model.sv
// Comparator model of the headphone and speaker temperature sensors
`timescale 1ns/100ps
`default_nettype none
module tpm_sensor_model (
  input  var int  hpTempC,
  input  var int  spkTempC,
  output logic    hpWarnComp,
  output logic    hpErrComp,
  output logic    spkWarnComp,
  output logic    spkErrComp
);
  assign hpWarnComp  = hpTempC >= tpm_pkg::WARN_TEMP_C;
  assign spkWarnComp = spkTempC >= tpm_pkg::WARN_TEMP_C;
  assign hpErrComp   = hpTempC >= tpm_pkg::ERR_TEMP_C;
  assign spkErrComp  = spkTempC >= tpm_pkg::ERR_TEMP_C;
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the thermal protection monitor
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int LIMIT = 20000;
  logic                       clk;
  logic                       reset;
  logic                       psel;
  logic                       penable;
  logic                       pwrite;
  logic [tpm_pkg::ADDR_W-1:0] paddr;
  logic [31:0]                pwdata;
  logic [3:0]                 pstrb;
  logic [31:0]                prdata;
  logic                       pready;
  logic                       pslverr;
  logic                       hpW, hpE, spkW, spkE;
  logic                       lSpk, rSpk, cpEn, pin, pinOe, sdAct;
  logic [3:0]                 flagEvent;
  logic [31:0]                rd;
  logic                       err;
  int                         hpTempC, spkTempC, n_mismatch, n_tests, cyc;
  int                         evCnt [4];
  int                         hpEn, spkEn, autoSd, outEn, pinCfg, en4, f0, f1, f2, sd, pv;

  tpm_monitor uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hpWarnComp(hpW), .hpErrComp(hpE),
    .spkWarnComp(spkW), .spkErrComp(spkE), .leftSpeakerOutputEnable(lSpk),
    .rightSpeakerOutputEnable(rSpk), .chargePumpEnable(cpEn), .tempStatusPin(pin),
    .tempStatusPinOe(pinOe), .flagEvent(flagEvent), .shutdownActive(sdAct));

  tpm_sensor_model sensor (.hpTempC(hpTempC), .spkTempC(spkTempC), .hpWarnComp(hpW),
    .hpErrComp(hpE), .spkWarnComp(spkW), .spkErrComp(spkE));

  always #25 clk = ~clk;

  always @(posedge clk)
  begin
    for (int i = 0; i < 4; i++)
      if (flagEvent[i] === 1'b1)
        evCnt[i]++;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [11:0] ba(input logic [9:0] idx);
    return {idx, 2'b00};
  endfunction

  function automatic int comp(input int h, input int s);
    return ((h >= tpm_pkg::ERR_TEMP_C) << 3) | ((h >= tpm_pkg::WARN_TEMP_C) << 2) |
           ((s >= tpm_pkg::ERR_TEMP_C) << 1) | (s >= tpm_pkg::WARN_TEMP_C);
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, err}, 32'h0);
  endtask

  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    hpTempC = 25;
    spkTempC = 25;
    n_mismatch = 0;
    n_tests = 0;
    cyc = 0;
    f0 = 0;
    for (int i = 0; i < 4; i++)
      evCnt[i] = 0;
    void'($urandom(46));
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rdchk(ba(tpm_pkg::IDX_ADD_CTRL1), 32'h100);
    rdchk(ba(tpm_pkg::IDX_FLAGS), 32'h0);
    rdchk(ba(tpm_pkg::IDX_MON_EN), 32'h6);
    rdchk(ba(tpm_pkg::IDX_OUT_EN), 32'h0);
    rdchk(ba(tpm_pkg::IDX_PIN_CFG), 32'h0);
    apb(1'b0, 12'h3fc, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    for (int s = 0; s < 40; s++)
    begin
      hpEn = $urandom_range(0, 1);
      spkEn = $urandom_range(0, 1);
      autoSd = $urandom_range(0, 1);
      outEn = $urandom_range(0, 7);
      pinCfg = $urandom_range(0, 3);
      en4 = hpEn * 12 + spkEn * 3;
      for (int i = 0; i < 4; i++)
        evCnt[i] = 0;
      f1 = comp(hpTempC, spkTempC) & en4;
      apb(1'b1, ba(tpm_pkg::IDX_MON_EN), (hpEn << 2) | (spkEn << 1));
      apb(1'b1, ba(tpm_pkg::IDX_ADD_CTRL1), autoSd << 8);
      apb(1'b1, ba(tpm_pkg::IDX_OUT_EN), outEn);
      apb(1'b1, ba(tpm_pkg::IDX_PIN_CFG), pinCfg);
      @(posedge clk);
      hpTempC <= $urandom_range(100, 170);
      spkTempC <= $urandom_range(100, 170);
      repeat (8) @(posedge clk);
      f2 = comp(hpTempC, spkTempC) & en4;
      sd = autoSd && (f2 & 10) != 0;
      pv = (pinCfg & 2) ? ((f2 & 10) != 0) : (f2 != 0);
      for (int i = 0; i < 4; i++)
        chk(evCnt[i], ((f1 & ~f0) >> i & 1) + ((f2 & ~f1) >> i & 1));
      chk({31'h0, sdAct}, sd);
      chk({29'h0, rSpk, lSpk, cpEn}, sd ? 0 : outEn);
      chk({30'h0, pinOe, pin}, (pinCfg & 1) * (2 + pv));
      apb(1'b1, ba(tpm_pkg::IDX_FLAGS), ~f2 & 15);
      rdchk(ba(tpm_pkg::IDX_FLAGS), f2);
      f0 = f2;
    end
    wrap_up();
  end
endmodule
`default_nettype wire
